// [bench/codec_ctrl_monitor.sv]
// port-level checks of the codec control block
`default_nettype none
module codec_ctrl_monitor
	import codec_ctrl_pkg::*;
(
	input wire logic         core_clk_i,
	input wire logic         srst_i,
	input wire logic         ctl_sclk_i,
	input wire logic         ctl_cs_n_i,
	input wire logic         ctl_dout_o,
	input wire logic         ctl_dout_oe_o,
	input wire logic         pcm_bclk_i,
	input wire logic         pcm_transmit_output_o,
	input wire logic         pcm_transmit_output_oe_o,
	input wire logic         dec_valid_o,
	input wire logic         dec_ready_i,
	input wire pcm_word_type dec_word_o,
	input wire logic         auxiliary_clock_select_o,
	input wire logic [1:0]   law_select_o,
	input wire logic         latch_output_pin_o,
	input wire logic [1:0]   tone_range_o,
	input wire logic         buzzer_o
);
	logic [2:0] bclk_r;
	logic       bedge;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	// bit clock history; allows one extra cycle of sampling delay
	always_ff @(posedge core_clk_i) begin
		bclk_r <= {bclk_r[1:0], pcm_bclk_i};
	end
	assign bedge = (bclk_r[0] != bclk_r[1]) || (bclk_r[1] != bclk_r[2]);
	chk_latch_reset: assert property ($fell(srst_i) |-> latch_output_pin_o)
		else $error("latch pin low after reset");
	chk_buzz_idle: assert property ($fell(srst_i) |-> !buzzer_o [*8])
		else $error("buzzer active while disabled");
	chk_aux_no_tx: assert property (auxiliary_clock_select_o && $past(auxiliary_clock_select_o) |-> !pcm_transmit_output_oe_o)
		else $error("pcm driven on auxiliary clock");
	chk_read_release: assert property (ctl_cs_n_i |=> !ctl_dout_oe_o)
		else $error("read data driven without select");
	chk_read_shift: assert property (ctl_dout_oe_o && $past(ctl_dout_oe_o) && $changed(ctl_dout_o) |-> !$past(ctl_sclk_i))
		else $error("read bit changed outside sclk low");
	chk_tx_launch: assert property ($rose(pcm_transmit_output_oe_o) |-> bedge)
		else $error("tx slot opened without bit clock edge");
	chk_tx_bit_move: assert property (pcm_transmit_output_oe_o && $past(pcm_transmit_output_oe_o) && $changed(pcm_transmit_output_o) |-> bedge)
		else $error("tx bit changed without bit clock edge");
	chk_cfg_hold: assert property (ctl_cs_n_i && $past(ctl_cs_n_i, 3) |-> $stable({law_select_o, tone_range_o, latch_output_pin_o}))
		else $error("configuration changed outside a frame");
	chk_fifo_hold: assert property (dec_valid_o && !dec_ready_i |=> dec_valid_o && $stable(dec_word_o))
		else $error("decoder word lost while stalled");
	cover property ($rose(pcm_transmit_output_oe_o));
	cover property (dec_valid_o && dec_ready_i);
	cover property ($rose(buzzer_o));
endmodule // codec_ctrl_monitor
bind codec_ctrl codec_ctrl_monitor mon_u (.*);
`default_nettype wire

// [bench/codec_ctrl_tb_top.sv]
// self-checking bench of the codec control block
`default_nettype none
module codec_ctrl_tb_top;
	import codec_ctrl_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [3:0]  idx;
		logic [7:0]  d;
		logic [7:0]  q;
		logic [11:0] o;
	} row_type;
	logic core_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic ctl_sclk_i = 1'b0;
	logic ctl_cs_n_i = 1'b1;
	logic ctl_din_i = 1'b0;
	logic dec_ready_i = 1'b0;
	logic remote_key_input_i = 1'b1;
	logic [15:0] enc_sample_i = 16'h003C;
	logic run = 1'b0;
	logic ctl_dout_o, ctl_dout_oe_o, pcm_bclk_i, pcm_fsync_i, pcm_receive_input_i, pcm_transmit_output_o;
	logic pcm_transmit_output_oe_o, dec_valid_o, rx_overrun_o, auxiliary_clock_select_o, companded_mode_o;
	logic amp_mute_o, latch_output_pin_o, preamp_gain_select_o, mic_bias_output_o, remote_key_output_o, buzzer_o;
	logic [1:0] clock_divider_o, law_select_o, tone_range_o;
	pcm_word_type dec_word_o;
	logic [7:0] got, q;
	int n_errors = 0;
	int comparisons = 0;
	int cyc = 0;
	int k;
	// tone range 11 never written
	row_type rows [8] = '{'{4'h0, 8'hC9, 8'hC9, 12'hCE0}, '{4'h1, 8'h21, 8'h21, 12'hCD0},
		'{4'hA, 8'hFE, 8'hEE, 12'hCDE}, '{4'hB, 8'h00, 8'h00, 12'hCDE}, '{4'h3, 8'h5A, 8'h00, 12'hCDE},
		'{4'h5, 8'h77, 8'h00, 12'hCDE}, '{4'h0, 8'h00, 8'h00, 12'h01E}, '{4'h1, 8'h00, 8'h00, 12'h02E}};
	logic [15:0] bz [3] = '{16'h2000, 16'hA020, 16'hE060};
	pcm_dsp_model far_u (
		.core_clk_i (core_clk_i),
		.run_i      (run),
		.send_i     (8'hA5),
		.dx_i       (pcm_transmit_output_o),
		.dx_oe_i    (pcm_transmit_output_oe_o),
		.bclk_o     (pcm_bclk_i),
		.fsync_o    (pcm_fsync_i),
		.dr_o       (pcm_receive_input_i),
		.got_o      (got)
	);
	codec_ctrl #(.DEBOUNCE_CYCLES(8), .BUZZ_PRESCALE(1)) dut_u (.*);
	always #2 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_errors++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge core_clk_i);
	endtask
	task automatic nfr(input int n);
		repeat (n) @(posedge pcm_fsync_i);
		tick(2);
	endtask
	// one 16-bit frame; read bits taken just before each rising sclk
	task automatic cc(input logic [3:0] idx, input logic rd, input logic [7:0] d);
		logic [15:0] w;
		w = {2'h0, idx, rd, 1'b0, d};
		ctl_cs_n_i = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			ctl_din_i = w[i];
			tick(4);
			if (i < 8)
				q[i] = ctl_dout_o;
			ctl_sclk_i = 1'b1;
			tick(4);
			ctl_sclk_i = 1'b0;
		end
		tick(4);
		ctl_cs_n_i = 1'b1;
		tick(4);
	endtask
	initial begin
		tick(16);
		srst_i = 1'b0;
		tick(1);
		check("latch pin", 17'(latch_output_pin_o), 17'h1);
		foreach (rows[i]) begin
			cc(rows[i].idx, 1'b0, rows[i].d);
			cc(rows[i].idx, 1'b1, 8'h00);
			check("readback", 17'(q), 17'(rows[i].q));
			check("config outs", 17'({clock_divider_o, companded_mode_o, law_select_o, amp_mute_o, latch_output_pin_o,
				auxiliary_clock_select_o, preamp_gain_select_o, mic_bias_output_o, tone_range_o}), 17'(rows[i].o));
		end
		$display("test registers done");
		cc(4'h0, 1'b0, 8'h20);
		cc(4'h1, 1'b0, 8'h04);
		run = 1'b1;
		nfr(3);
		cc(4'h2, 1'b1, 8'h00);
		check("rx byte", 17'(q), 17'h0A5);
		check("tx slot", 17'(got), 17'h03C);
		check("fifo head", dec_word_o, 17'h000A5);
		// fifo stalled until it refuses
		nfr(16);
		run = 1'b0;
		check("overrun", 17'(rx_overrun_o), 17'h1);
		k = 0;
		dec_ready_i = 1'b1;
		while (dec_valid_o === 1'b1 && k < 40) begin
			tick(1);
			k++;
		end
		check("fifo depth", 17'(k), 17'd16);
		cc(4'h2, 1'b0, 8'h5E);
		check("overrun clear", 17'(rx_overrun_o), 17'h0);
		$display("test pcm fifo done");
		cc(4'h3, 1'b0, 8'hC3);
		dec_ready_i = 1'b0;
		cc(4'h1, 1'b0, 8'h1C);
		run = 1'b1;
		nfr(2);
		check("tx override", 17'(got), 17'h0C3);
		check("rx override", dec_word_o, 17'h0005E);
		dec_ready_i = 1'b1;
		cc(4'h1, 1'b0, 8'h04);
		cc(4'h0, 1'b0, 8'h21);
		nfr(3);
		check("loopback", 17'(got), 17'h0A5);
		check("amp mute", 17'(amp_mute_o), 17'h1);
		enc_sample_i = 16'h0081;
		cc(4'h0, 1'b0, 8'h22);
		nfr(3);
		check("seven bits", 17'(got), 17'h040);
		cc(4'h2, 1'b1, 8'h00);
		check("rx seven", 17'(q), 17'h0A4);
		cc(4'h1, 1'b0, 8'h00);
		dec_ready_i = 1'b0;
		nfr(3);
		check("tx off", 17'(got), 17'h040);
		check("no decode", 17'(dec_valid_o), 17'h0);
		run = 1'b0;
		$display("test pcm modes done");
		foreach (bz[i]) begin
			cc(4'hB, 1'b0, bz[i][15:8]);
			k = 0;
			repeat (128) begin
				tick(1);
				k += int'(buzzer_o);
			end
			check("buzzer high", 17'(k), 17'(bz[i][7:0]));
		end
		$display("test buzzer done");
		cc(4'hA, 1'b0, 8'h80);
		remote_key_input_i = 1'b0;
		tick(4);
		remote_key_input_i = 1'b1;
		tick(20);
		check("key glitch", 17'(remote_key_output_o), 17'h0);
		remote_key_input_i = 1'b0;
		tick(30);
		check("key out", 17'(remote_key_output_o), 17'h1);
		cc(4'hA, 1'b1, 8'h00);
		check("key flag", 17'(q), 17'h090);
		remote_key_input_i = 1'b1;
		tick(30);
		cc(4'hA, 1'b0, 8'h80);
		cc(4'hA, 1'b1, 8'h00);
		check("flag cleared", 17'(q), 17'h080);
		$display("test key done");
		cc(4'h1, 1'b0, 8'h20);
		srst_i = 1'b1;
		tick(3);
		srst_i = 1'b0;
		tick(1);
		check("latch reset", 17'(latch_output_pin_o), 17'h1);
		$display("test second reset done");
		stop_test();
	end
endmodule // codec_ctrl_tb_top
`default_nettype wire

// [bench/pcm_dsp_model.sv]
// dsp end of the pcm link: bit clock, frame sync, one sent byte, collected slot bits
`default_nettype none
module pcm_dsp_model (
	input  wire logic       core_clk_i,
	input  wire logic       run_i,
	input  wire logic [7:0] send_i,
	input  wire logic       dx_i,
	input  wire logic       dx_oe_i,
	output logic            bclk_o,
	output logic            fsync_o,
	output logic            dr_o,
	output logic [7:0]      got_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] div;
	logic [4:0] pos;
	initial begin
		{bclk_o, fsync_o, dr_o, got_o, div, pos} = '0;
	end
	// clock stands still when not running; eight core cycles per bit
	always @(negedge core_clk_i) begin
		div <= div + 2'h1;
		if (run_i && div == 2'h3) begin
			bclk_o <= ~bclk_o;
			if (!bclk_o) begin
				pos     <= pos + 5'h1;
				fsync_o <= (pos == 5'h1F);
				// delayed slot at positions 1 to 8; idle bits toggle so stale data shows
				dr_o    <= (pos < 5'h8) ? send_i[3'h7 - pos[2:0]] : ~dr_o;
			end else if (dx_oe_i) begin
				got_o <= {got_o[6:0], dx_i};
			end
		end
	end
endmodule // pcm_dsp_model
`default_nettype wire

// [core/codec_ctrl.sv]
// codec control registers, serial control channel, pcm framing, key detector and buzzer
`default_nettype none

module pcm_fifo #(
	parameter int unsigned WIDTH = 17,
	parameter int unsigned DEPTH = 16
) (
	input  wire logic             core_clk_i,
	input  wire logic             srst_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      count_r;
	logic             push;
	logic             pop;

	assign in_ready_o  = (count_r != (AW+1)'(DEPTH));
	assign out_valid_o = (count_r != '0);
	assign out_data_o  = mem_r[rd_ptr_r];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	always_ff @(posedge core_clk_i) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data_i;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= AW'(wr_ptr_r + 1'b1);
			end
			if (pop) begin
				rd_ptr_r <= AW'(rd_ptr_r + 1'b1);
			end
			count_r <= (AW+1)'(count_r + push - pop);
		end
	end
endmodule // pcm_fifo

module codec_ctrl
	import codec_ctrl_pkg::*;
#(
	parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC,
	parameter int unsigned BUZZ_PRESCALE   = BUZ_PRESCALE
) (
	input  wire logic         core_clk_i,
	input  wire logic         srst_i,
	// serial control channel
	input  wire logic         ctl_sclk_i,
	input  wire logic         ctl_cs_n_i,
	input  wire logic         ctl_din_i,
	output logic              ctl_dout_o,
	output logic              ctl_dout_oe_o,
	// pcm link
	input  wire logic         pcm_bclk_i,
	input  wire logic         pcm_fsync_i,
	input  wire logic         pcm_receive_input_i,
	output logic              pcm_transmit_output_o,
	output logic              pcm_transmit_output_oe_o,
	// codec core side
	input  wire logic [15:0]  enc_sample_i,
	output logic              dec_valid_o,
	input  wire logic         dec_ready_i,
	output pcm_word_type      dec_word_o,
	output logic              rx_overrun_o,
	// configuration towards analog and tone blocks
	output logic [1:0]        clock_divider_o,
	output logic              auxiliary_clock_select_o,
	output logic              companded_mode_o,
	output logic [1:0]        law_select_o,
	output logic              amp_mute_o,
	output logic              latch_output_pin_o,
	output logic              preamp_gain_select_o,
	output logic              mic_bias_output_o,
	output logic [1:0]        tone_range_o,
	// remote key and buzzer
	input  wire logic         remote_key_input_i,
	output logic              remote_key_output_o,
	output logic              buzzer_o
);
	logic [7:0]  clock_coding_config_r;
	logic [7:0]  pcm_interface_config_r;
	logic [7:0]  receive_pcm_data_r;
	logic [7:0]  rx_host_data_r;
	logic [7:0]  transmit_pcm_data_r;
	logic [7:0]  remote_bias_tone_config_r;
	logic [7:0]  buzzer_config_r;

	// control channel: 16 clocks per frame, address byte then data byte
	logic        sclk_d_r;
	logic [4:0]  bit_cnt_r;
	logic [15:0] ctl_shift_r;
	logic [7:0]  rd_shift_r;
	logic        ctl_rise;
	logic        ctl_fall;
	logic [3:0]  cmd_addr;
	logic [3:0]  rd_addr;
	logic        cmd_read;
	logic        cmd_read_r;
	logic        wr_commit;
	logic [7:0]  rd_value;
	logic [7:0]  wr_data;

	assign ctl_rise  = ctl_sclk_i && !sclk_d_r && !ctl_cs_n_i;
	assign ctl_fall  = !ctl_sclk_i && sclk_d_r && !ctl_cs_n_i;
	// command byte sits at bits 14:7 once the last data bit arrives
	assign cmd_addr  = ctl_shift_r[7+CMD_ADDR_LSB+:4];
	// at the 8th rise the command byte is seven stored bits plus din
	assign rd_addr   = ctl_shift_r[CMD_ADDR_LSB-1+:4];
	assign cmd_read  = cmd_read_r;
	assign wr_data   = {ctl_shift_r[6:0], ctl_din_i};
	// only the last data bit commits a write
	assign wr_commit = ctl_rise && bit_cnt_r == 5'd15 && !ctl_shift_r[7+CMD_READ_BIT];

	always_comb begin
		case (rd_addr)
			CLOCK_CODING_IDX: rd_value = clock_coding_config_r;
			PCM_IFACE_IDX:    rd_value = pcm_interface_config_r;
			RX_PCM_DATA_IDX:  rd_value = receive_pcm_data_r;
			REMOTE_CFG_IDX:   rd_value = remote_bias_tone_config_r;
			BUZZER_CFG_IDX:   rd_value = buzzer_config_r;
			default:          rd_value = REG_RESET;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			sclk_d_r      <= 1'b0;
			bit_cnt_r     <= '0;
			ctl_shift_r   <= '0;
			rd_shift_r    <= '0;
			cmd_read_r    <= 1'b0;
			ctl_dout_o    <= 1'b0;
			ctl_dout_oe_o <= 1'b0;
		end else begin
			sclk_d_r <= ctl_sclk_i;
			if (ctl_cs_n_i) begin
				bit_cnt_r     <= '0;
				ctl_dout_oe_o <= 1'b0;
			end else if (ctl_rise) begin
				ctl_shift_r <= {ctl_shift_r[14:0], ctl_din_i};
				bit_cnt_r   <= (bit_cnt_r == 5'd16) ? bit_cnt_r : 5'(bit_cnt_r + 1'b1);
				if (bit_cnt_r == 5'd7) begin
					rd_shift_r <= rd_value;
					cmd_read_r <= ctl_shift_r[CMD_READ_BIT-1];
				end
			end else if (ctl_fall && bit_cnt_r >= 5'd8 && bit_cnt_r < 5'd16 && cmd_read) begin
				ctl_dout_o    <= rd_shift_r[7];
				rd_shift_r    <= {rd_shift_r[6:0], 1'b0};
				ctl_dout_oe_o <= 1'b1;
			end else if (bit_cnt_r == 5'd16) begin
				ctl_dout_oe_o <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			clock_coding_config_r  <= REG_RESET;
			pcm_interface_config_r <= REG_RESET;
			rx_host_data_r         <= REG_RESET;
			transmit_pcm_data_r    <= REG_RESET;
			buzzer_config_r        <= REG_RESET;
		end else if (wr_commit) begin
			case (cmd_addr)
				CLOCK_CODING_IDX: clock_coding_config_r <= wr_data;
				PCM_IFACE_IDX:    pcm_interface_config_r <= wr_data;
				RX_PCM_DATA_IDX:  rx_host_data_r <= wr_data;
				TX_PCM_DATA_IDX:  transmit_pcm_data_r <= wr_data;
				BUZZER_CFG_IDX:   buzzer_config_r <= wr_data;
				default:          ;
			endcase
		end
	end

	// field decode
	logic       companded;
	logic       loopback;
	logic       seven_bit;
	logic       reverse_timing;
	logic       delayed_timing;
	logic       xfer_active;
	logic [5:0] slot_len;
	logic [5:0] slot_start;

	assign companded      = clock_coding_config_r[COMPANDED_BIT];
	assign loopback       = clock_coding_config_r[LOOPBACK_BIT];
	assign seven_bit      = companded && clock_coding_config_r[SEVEN_BIT_BIT];
	assign delayed_timing = !pcm_interface_config_r[TIMING_HI_BIT];
	assign reverse_timing = pcm_interface_config_r[TIMING_HI_BIT] && pcm_interface_config_r[TIMING_LO_BIT];
	// pcm needs the main clock; on the auxiliary clock only the pcm transfer stops
	assign xfer_active    = pcm_interface_config_r[XFER_EN_BIT] && !pcm_interface_config_r[CLK_SRC_BIT];
	assign slot_len       = companded ? SLOT_COMPANDED : SLOT_LINEAR;
	always_comb begin
		slot_start = {5'd0, delayed_timing};
		if (companded && pcm_interface_config_r[CHAN_SEL_BIT]) begin
			slot_start = 6'(slot_start + SLOT_COMPANDED
				+ (clock_coding_config_r[FRAME_FMT_BIT] ? FMT2_GAP : 6'd0));
		end
	end

	// pcm bit engine; reverse timing swaps the launch and capture edges
	logic        bclk_d_r;
	logic        fs_d_r;
	logic [5:0]  tx_pos_r;
	logic [5:0]  rx_pos_r;
	logic [15:0] tx_word_r;
	logic [15:0] rx_shift_r;
	logic        bclk_rise;
	logic        bclk_fall;
	logic        fs_start;
	logic        launch_edge;
	logic        capture_edge;
	logic [5:0]  tx_idx;
	logic [5:0]  tx_next_pos;
	logic [15:0] tx_word_nxt;
	logic [15:0] tx_src;
	logic [5:0]  rx_idx;
	logic        tx_in_slot;
	logic        rx_in_slot;
	logic        rx_last;
	logic [15:0] rx_word;
	logic        fifo_ready;
	pcm_word_type fifo_in;

	assign bclk_rise    = pcm_bclk_i && !bclk_d_r;
	assign bclk_fall    = !pcm_bclk_i && bclk_d_r;
	assign fs_start     = pcm_fsync_i && !fs_d_r;
	assign launch_edge  = reverse_timing ? bclk_fall : bclk_rise;
	assign capture_edge = reverse_timing ? bclk_rise : bclk_fall;
	// position of the bit launched now; the frame-start edge is position 0
	assign tx_next_pos  = fs_start ? 6'd0 : ((tx_pos_r == 6'h3F) ? tx_pos_r : 6'(tx_pos_r + 1'b1));
	assign tx_idx       = 6'(tx_next_pos - slot_start);
	// the frame-start edge launches from the word being loaded
	assign tx_src       = fs_start ? tx_word_nxt : tx_word_r;
	assign rx_idx       = 6'(rx_pos_r - slot_start);
	assign tx_in_slot   = tx_next_pos >= slot_start && tx_idx < slot_len;
	assign rx_in_slot   = rx_pos_r >= slot_start && rx_idx < slot_len;
	assign rx_last      = rx_in_slot && rx_idx == 6'(slot_len - 1'b1);
	assign rx_word      = {rx_shift_r[14:0], pcm_receive_input_i && !(seven_bit && rx_last)};
	assign fifo_in.linear = !companded;
	// host byte replaces the line byte on the way to the decoder
	assign fifo_in.sample = pcm_interface_config_r[RX_OVERRIDE_BIT] ? {8'h00, rx_host_data_r}
		: (companded ? {8'h00, rx_word[7:0]} : rx_word);

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			bclk_d_r <= 1'b0;
			fs_d_r   <= 1'b0;
			tx_pos_r <= 6'h3F;
			rx_pos_r <= 6'h3F;
		end else begin
			bclk_d_r <= pcm_bclk_i;
			fs_d_r   <= pcm_fsync_i;
			if (fs_start) begin
				tx_pos_r <= '0;
				rx_pos_r <= '0;
			end else begin
				if (launch_edge && tx_pos_r != 6'h3F) begin
					tx_pos_r <= 6'(tx_pos_r + 1'b1);
				end
				if (capture_edge && rx_pos_r != 6'h3F) begin
					rx_pos_r <= 6'(rx_pos_r + 1'b1);
				end
			end
		end
	end

	// transmit word chosen once per frame
	always_comb begin
		if (pcm_interface_config_r[TX_OVERRIDE_BIT]) begin
			tx_word_nxt = {transmit_pcm_data_r, 8'h00};
		end else if (loopback) begin
			tx_word_nxt = {receive_pcm_data_r, 8'h00};
		end else begin
			tx_word_nxt = companded ? {enc_sample_i[7:0], 8'h00} : enc_sample_i;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			tx_word_r <= '0;
		end else if (fs_start) begin
			tx_word_r <= tx_word_nxt;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			pcm_transmit_output_o    <= 1'b0;
			pcm_transmit_output_oe_o <= 1'b0;
		end else if (!xfer_active) begin
			pcm_transmit_output_oe_o <= 1'b0;
		end else if (launch_edge) begin
			pcm_transmit_output_o    <= tx_src[4'(4'd15 - tx_idx[3:0])];
			pcm_transmit_output_oe_o <= tx_in_slot && !(seven_bit && tx_idx == 6'd7);
		end else if (tx_pos_r == 6'h3F) begin
			pcm_transmit_output_oe_o <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			rx_shift_r         <= '0;
			receive_pcm_data_r <= REG_RESET;
			rx_overrun_o       <= 1'b0;
		end else begin
			// a new overrun in the clearing cycle still lands
			if (wr_commit && cmd_addr == RX_PCM_DATA_IDX) begin
				rx_overrun_o <= 1'b0;
			end
			if (capture_edge && rx_in_slot && xfer_active) begin
				rx_shift_r <= rx_word;
				if (rx_last) begin
					receive_pcm_data_r <= rx_word[7:0];
					// a full buffer drops the frame rather than stall the line
					if (!loopback && !fifo_ready) begin
						rx_overrun_o <= 1'b1;
					end
				end
			end
		end
	end

	pcm_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.core_clk_i  (core_clk_i),
		.srst_i      (srst_i),
		// no decode when disabled or in loopback
		.in_valid_i  (capture_edge && rx_last && xfer_active && !loopback),
		.in_ready_o  (fifo_ready),
		.in_data_i   (fifo_in),
		.out_valid_o (dec_valid_o),
		.out_ready_i (dec_ready_i),
		.out_data_o  (dec_word_o)
	);

	// remote key detector
	logic [$clog2(DEBOUNCE_CYCLES+1)-1:0] deb_cnt_r;
	logic key_pressed_r;
	logic key_en;

	assign key_en = remote_bias_tone_config_r[KEY_EN_BIT];

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			deb_cnt_r     <= '0;
			key_pressed_r <= 1'b0;
		end else if (!key_en || (!remote_key_input_i) == key_pressed_r) begin
			deb_cnt_r <= '0;
		end else if (deb_cnt_r == ($bits(deb_cnt_r))'(DEBOUNCE_CYCLES - 1)) begin
			deb_cnt_r     <= '0;
			key_pressed_r <= !remote_key_input_i;
		end else begin
			deb_cnt_r <= ($bits(deb_cnt_r))'(deb_cnt_r + 1'b1);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			remote_bias_tone_config_r <= REG_RESET;
		end else begin
			if (wr_commit && cmd_addr == REMOTE_CFG_IDX) begin
				remote_bias_tone_config_r <= {wr_data[7:5], 1'b0, wr_data[3:0]};
			end
			// a detection in the clearing cycle still lands
			if (key_en && key_pressed_r) begin
				remote_bias_tone_config_r[KEY_FLAG_BIT] <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			remote_key_output_o <= 1'b0;
		end else begin
			remote_key_output_o <= key_en && ((remote_bias_tone_config_r[KEY_LATCH_BIT]
				? remote_bias_tone_config_r[KEY_FLAG_BIT] : key_pressed_r)
				^ remote_bias_tone_config_r[KEY_INVERT_BIT]);
		end
	end

	// buzzer pwm: 128-step period gives 0.78125 percent per duty count
	logic [$clog2(BUZZ_PRESCALE+1)-1:0] buz_pre_r;
	logic [6:0] buz_cnt_r;

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			buz_pre_r <= '0;
			buz_cnt_r <= '0;
			buzzer_o  <= 1'b0;
		end else begin
			if (buz_pre_r == ($bits(buz_pre_r))'(BUZZ_PRESCALE - 1)) begin
				buz_pre_r <= '0;
				buz_cnt_r <= (buz_cnt_r == BUZ_PERIOD) ? 7'd0 : 7'(buz_cnt_r + 1'b1);
			end else begin
				buz_pre_r <= ($bits(buz_pre_r))'(buz_pre_r + 1'b1);
			end
			buzzer_o <= buzzer_config_r[BUZ_EN_BIT]
				&& ((buz_cnt_r < {1'b0, buzzer_config_r[BUZ_DUTY_LSB+:6]})
				^ buzzer_config_r[BUZ_POL_BIT]);
		end
	end

	// static configuration outputs
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			clock_divider_o          <= '0;
			auxiliary_clock_select_o <= 1'b0;
			companded_mode_o         <= 1'b0;
			law_select_o             <= '0;
			amp_mute_o               <= 1'b0;
			latch_output_pin_o       <= 1'b1;
			preamp_gain_select_o     <= 1'b0;
			mic_bias_output_o        <= 1'b0;
			tone_range_o             <= '0;
		end else begin
			clock_divider_o          <= clock_coding_config_r[CLKDIV_LSB+:2];
			auxiliary_clock_select_o <= pcm_interface_config_r[CLK_SRC_BIT];
			companded_mode_o         <= companded;
			law_select_o             <= clock_coding_config_r[LAW_LSB+:2];
			amp_mute_o               <= loopback;
			latch_output_pin_o       <= !pcm_interface_config_r[LATCH_CTRL_BIT];
			preamp_gain_select_o     <= remote_bias_tone_config_r[PREAMP_BIT];
			mic_bias_output_o        <= remote_bias_tone_config_r[MIC_BIAS_BIT];
			tone_range_o             <= remote_bias_tone_config_r[TONE_RANGE_LSB+:2];
		end
	end
endmodule // codec_ctrl
`default_nettype wire

// [core/codec_ctrl_pkg.sv]
// shared constants and types of the codec control register bank
`default_nettype none
package codec_ctrl_pkg;
	// register indices on the serial control channel
	localparam logic [3:0] CLOCK_CODING_IDX  = 4'h0;
	localparam logic [3:0] PCM_IFACE_IDX     = 4'h1;
	localparam logic [3:0] RX_PCM_DATA_IDX   = 4'h2;
	localparam logic [3:0] TX_PCM_DATA_IDX   = 4'h3;
	localparam logic [3:0] REMOTE_CFG_IDX    = 4'hA;
	localparam logic [3:0] BUZZER_CFG_IDX    = 4'hB;
	// first control byte: address field and read flag
	localparam int unsigned CMD_ADDR_LSB     = 2;
	localparam int unsigned CMD_READ_BIT     = 1;
	localparam logic [7:0]  REG_RESET        = 8'h00;
	// clock_coding_config fields
	localparam int unsigned CLKDIV_LSB       = 6;
	localparam int unsigned COMPANDED_BIT    = 5;
	localparam int unsigned LAW_LSB          = 3;
	localparam int unsigned FRAME_FMT_BIT    = 2;
	localparam int unsigned SEVEN_BIT_BIT    = 1;
	localparam int unsigned LOOPBACK_BIT     = 0;
	// pcm_interface_config fields
	localparam int unsigned TIMING_HI_BIT    = 7;
	localparam int unsigned TIMING_LO_BIT    = 6;
	localparam int unsigned LATCH_CTRL_BIT   = 5;
	localparam int unsigned RX_OVERRIDE_BIT  = 4;
	localparam int unsigned TX_OVERRIDE_BIT  = 3;
	localparam int unsigned XFER_EN_BIT      = 2;
	localparam int unsigned CHAN_SEL_BIT     = 1;
	localparam int unsigned CLK_SRC_BIT      = 0;
	// remote_bias_tone_config fields
	localparam int unsigned KEY_EN_BIT       = 7;
	localparam int unsigned KEY_LATCH_BIT    = 6;
	localparam int unsigned KEY_INVERT_BIT   = 5;
	localparam int unsigned KEY_FLAG_BIT     = 4;
	localparam int unsigned PREAMP_BIT       = 3;
	localparam int unsigned MIC_BIAS_BIT     = 2;
	localparam int unsigned TONE_RANGE_LSB   = 0;
	// buzzer_config fields
	localparam int unsigned BUZ_EN_BIT       = 7;
	localparam int unsigned BUZ_POL_BIT      = 6;
	localparam int unsigned BUZ_DUTY_LSB     = 0;
	// pcm slot geometry and buzzer period
	localparam logic [5:0]  SLOT_COMPANDED   = 6'd8;
	localparam logic [5:0]  SLOT_LINEAR      = 6'd16;
	localparam logic [5:0]  FMT2_GAP         = 6'd2;
	localparam logic [6:0]  BUZ_PERIOD       = 7'h7F;
	// timing
	localparam int unsigned CLK_HZ           = 250_000_000;
	localparam int unsigned DEBOUNCE_MS      = 50;
	localparam int unsigned DEBOUNCE_CYC     = CLK_HZ / 1000 * DEBOUNCE_MS;
	localparam int unsigned BUZ_PRESCALE     = 16;
	localparam int unsigned FIFO_DEPTH       = 16;
	localparam int unsigned FIFO_WIDTH       = 17;
	typedef struct packed {
		logic        linear;
		logic [15:0] sample;
	} pcm_word_type;
endpackage
`default_nettype wire
